// File: hdl/adcti_control.sv
// Converter sampling, conversion trigger and interrupt control
`timescale 1ns/10ps
module adcti_control
  import adcti_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  // Configuration words
  input  wire adcti_cfg_t                 cfg,
  // Sample control bit strobes from software
  input  wire logic                       sampleSetStrobe,
  input  wire logic                       sampleClearStrobe,
  // Interrupt flag, enable and priority from software
  input  wire logic                       irqFlagClear,
  input  wire logic                       converterIrqEnable,
  input  wire logic                       prioWrite,
  input  wire logic [2:0]                 prioWdata,
  input  wire logic [1:0]                 subprioWdata,
  // Other interrupt sources and CPU state
  input  wire adcti_src_t [NUM_VEC-1:0]   otherSources,
  input  wire logic [2:0]                 curGroup,
  input  wire logic [1:0]                 curSub,
  input  wire logic [31:0]                exceptionBase,
  input  wire logic [4:0]                 vectorSpacing,
  // Analog front end
  input  wire logic                       convertDoneAnalog,
  output logic                            sampleActive,
  output logic                            convertActive,
  output logic [3:0]                      channelSel,
  output logic [15:0]                     analogPinMask,
  // Status
  output logic                            sampleControlBit,
  output logic                            conversionDone,
  output logic                            converterIrqFlag,
  output logic [NUM_IRQ-1:0]              irqFlagBits,
  output logic [2:0]                      converterIrqPriority,
  output logic [1:0]                      converterIrqSubpriority,
  // Interrupt controller result
  output logic                            cpuIrqRequest,
  output logic [5:0]                      irqVector,
  output logic [31:0]                     irqVectorAddr
);

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcti_state_t;

  adcti_state_t state_reg;
  adcti_state_t state_next;

  logic        moduleOn;
  logic [2:0]  conversionTriggerSource;
  logic        autoSampleStart;
  logic        inputScanEnable;
  logic [3:0]  samplesPerInterrupt;
  logic [4:0]  autoSampleTime;
  logic [7:0]  convClockSel;
  logic        tadTick;

  logic        sample_control_bit_reg;
  logic [4:0]  sampCnt_reg;
  logic [3:0]  convCnt_reg;
  logic [3:0]  smpCnt_reg;
  logic [3:0]  scanPtr_reg;
  logic        done_reg;
  logic        flag_reg;
  logic [2:0]  prio_reg;
  logic [1:0]  sub_reg;

  logic        autoEnd;
  logic        convStart;
  logic        convEnd;
  logic        irqEvent;
  logic [4:0]  sampleLimit;
  logic [3:0]  scanNext;
  logic        scanHit;

  adcti_src_t [NUM_VEC-1:0] allSources;

  // Field extraction from the configuration words
  assign moduleOn                = cfg.controlRegOne[CR1_ON_BIT];
  assign conversionTriggerSource = cfg.controlRegOne[CR1_CONVERSION_TRIGGER_SOURCE_HI:CR1_CONVERSION_TRIGGER_SOURCE_LO];
  assign autoSampleStart         = cfg.controlRegOne[CR1_AUTO_SAMPLE_START_BIT];
  assign inputScanEnable         = cfg.controlRegTwo[CR2_INPUT_SCAN_ENABLE_BIT];
  assign samplesPerInterrupt     = cfg.controlRegTwo[CR2_SMPI_HI:CR2_SMPI_LO];
  assign autoSampleTime          = cfg.controlRegThree[CR3_SAMC_HI:CR3_SAMC_LO];
  assign convClockSel            = cfg.controlRegThree[CR3_ADCS_HI:CR3_ADCS_LO];

  // Conversion clock runs only while the module is on
  adcti_tad_divider uTad (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .run     (moduleOn),
    .divSel  (convClockSel),
    .tadTick (tadTick)
  );

  // A zero sample time still gives one period so sampling is never skipped
  assign sampleLimit = (autoSampleTime == 5'h00) ? 5'h01 : autoSampleTime;

  // Sample time counter ends sampling only in the automatic trigger mode
  assign autoEnd = (state_reg == ST_SAMPLE)
                && (conversionTriggerSource == TRIG_AUTO)
                && tadTick && (sampCnt_reg + 5'h01 >= sampleLimit);

  // Manual trigger: the sample bit falling is the start of conversion
  assign convStart = (state_reg == ST_SAMPLE) && (autoEnd ||
                     (conversionTriggerSource == TRIG_MANUAL && !sample_control_bit_reg));

  // Conversion lasts a fixed number of periods, or until the front end says done
  assign convEnd = (state_reg == ST_CONVERT)
                && (convertDoneAnalog || (tadTick && convCnt_reg == CONV_TADS - 4'h1));

  // Interrupt event once the selected number of samples is complete
  assign irqEvent = convEnd && (smpCnt_reg == samplesPerInterrupt);

  // State machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (moduleOn && sample_control_bit_reg) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (!moduleOn) begin
          state_next = ST_IDLE;
        end else if (convStart) begin
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!moduleOn) begin
          state_next = ST_IDLE;
        end else if (convEnd) begin
          state_next = (autoSampleStart && moduleOn) ? ST_SAMPLE : ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sample control bit: software strobes, cleared by the counter, set again by auto start
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sample_control_bit_reg <= 1'b0;
    end else if (!moduleOn) begin
      sample_control_bit_reg <= sampleSetStrobe;
    end else if (autoEnd) begin
      sample_control_bit_reg <= 1'b0;
    end else if (convEnd && autoSampleStart) begin
      sample_control_bit_reg <= 1'b1;
    end else if (sampleSetStrobe) begin
      sample_control_bit_reg <= 1'b1;
    end else if (sampleClearStrobe) begin
      sample_control_bit_reg <= 1'b0;
    end
  end

  // Sample time count, only consulted in automatic trigger mode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sampCnt_reg <= 5'h00;
    end else if (state_reg != ST_SAMPLE || conversionTriggerSource != TRIG_AUTO) begin
      sampCnt_reg <= 5'h00;
    end else if (tadTick) begin
      sampCnt_reg <= sampCnt_reg + 5'h01;
    end
  end

  // Conversion period count
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      convCnt_reg <= 4'h0;
    end else if (state_reg != ST_CONVERT) begin
      convCnt_reg <= 4'h0;
    end else if (tadTick) begin
      convCnt_reg <= convCnt_reg + 4'h1;
    end
  end

  // Done bit: set at each finished conversion, dropped when the next one starts
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else if (convEnd) begin
      done_reg <= 1'b1;
    end else if (convStart) begin
      done_reg <= 1'b0;
    end
  end

  // Samples counted toward the next interrupt; a setting of zero fires every sample
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      smpCnt_reg <= 4'h0;
    end else if (!moduleOn) begin
      smpCnt_reg <= 4'h0;
    end else if (irqEvent) begin
      smpCnt_reg <= 4'h0;
    end else if (convEnd) begin
      smpCnt_reg <= smpCnt_reg + 4'h1;
    end
  end

  // Interrupt flag: sticky, set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
    end else if (irqEvent) begin
      flag_reg <= 1'b1;
    end else if (irqFlagClear) begin
      flag_reg <= 1'b0;
    end
  end

  // Priority group and subpriority, group defaults to four
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prio_reg <= PRIO_RESET;
      sub_reg  <= SUBPRIO_RESET;
    end else if (prioWrite) begin
      prio_reg <= prioWdata;
      sub_reg  <= subprioWdata;
    end
  end

  // Next scan entry after the current pointer, wrapping round
  always_comb begin
    scanNext = scanPtr_reg;
    scanHit  = 1'b0;
    for (int k = 1; k <= 16; k++) begin
      if (!scanHit && cfg.scanSelectReg[4'(scanPtr_reg + 4'(k))]) begin
        scanNext = 4'(scanPtr_reg + 4'(k));
        scanHit  = 1'b1;
      end
    end
  end

  // Scan pointer moves on after each conversion
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scanPtr_reg <= 4'hf;
    end else if (!inputScanEnable || !moduleOn) begin
      scanPtr_reg <= 4'hf;
    end else if (convEnd && scanHit) begin
      scanPtr_reg <= scanNext;
    end
  end

  // Input select: scan list counts only while scanning is enabled
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      channelSel <= 4'h0;
    end else if (inputScanEnable && scanHit) begin
      channelSel <= scanNext;
    end else begin
      channelSel <= cfg.positiveInputSel;
    end
  end

  // Pins with a cleared configuration bit are analog
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      analogPinMask <= 16'h0000;
    end else begin
      analogPinMask <= ~cfg.portConfigReg;
    end
  end

  // Front end strobes and status, all from flip-flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sampleActive  <= 1'b0;
      convertActive <= 1'b0;
    end else begin
      sampleActive  <= (state_next == ST_SAMPLE);
      convertActive <= (state_next == ST_CONVERT);
    end
  end

  assign sampleControlBit        = sample_control_bit_reg;
  assign conversionDone          = done_reg;
  assign converterIrqFlag        = flag_reg;
  assign converterIrqPriority    = prio_reg;
  assign converterIrqSubpriority = sub_reg;

  // Flag image at the converter's request number
  always_comb begin
    irqFlagBits              = '0;
    irqFlagBits[ADC_IRQ_NUM] = flag_reg;
  end

  // Converter takes its vector slot among the other sources
  always_comb begin
    allSources                    = otherSources;
    allSources[ADC_VECTOR].flag   = flag_reg;
    allSources[ADC_VECTOR].enable = converterIrqEnable;
    allSources[ADC_VECTOR].group  = prio_reg;
    allSources[ADC_VECTOR].sub    = sub_reg;
  end

  // Arbitration across all sources and vector placement
  adcti_irq_arbiter uArb (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .sources       (allSources),
    .curGroup      (curGroup),
    .curSub        (curSub),
    .exceptionBase (exceptionBase),
    .vectorSpacing (vectorSpacing),
    .cpuIrqRequest (cpuIrqRequest),
    .irqVector     (irqVector),
    .irqVectorAddr (irqVectorAddr)
  );

endmodule : adcti_control

// File: hdl/adcti_irq_arbiter.sv
// Interrupt arbiter: group, subpriority, natural order and vector address
`timescale 1ns/10ps
module adcti_irq_arbiter
  import adcti_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // Sources, index is vector number
  input  wire adcti_src_t [NUM_VEC-1:0] sources,
  // Level of the routine now running
  input  wire logic [2:0]           curGroup,
  input  wire logic [1:0]           curSub,
  // Vector placement
  input  wire logic [31:0]          exceptionBase,
  input  wire logic [4:0]           vectorSpacing,
  // Result
  output logic                      cpuIrqRequest,
  output logic [5:0]                irqVector,
  output logic [31:0]               irqVectorAddr
);

  logic [NUM_VEC-1:0] live;
  logic [4:0]         key [NUM_VEC];
  logic [4:0]         bestKey;
  logic [5:0]         bestVec;
  logic               anyLive;
  logic [31:0]        addrNext;

  // Per source: pending, enabled and not in group zero
  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g++) begin : gSrc
      assign live[g] = sources[g].flag & sources[g].enable & (sources[g].group != PRIO_OFF);
      assign key[g]  = {sources[g].group, sources[g].sub};
    end
  endgenerate

  // Scan from top vector down; ties go to the lower vector
  always_comb begin
    bestKey = 5'h00;
    bestVec = 6'h00;
    anyLive = 1'b0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (live[i] && (!anyLive || key[i] >= bestKey)) begin
        bestKey = key[i];
        bestVec = 6'(i);
        anyLive = 1'b1;
      end
    end
  end

  // Vector address scales with the spacing code
  assign addrNext = exceptionBase + VEC_BASE_OFS
                  + ((32'(bestVec) * 32'(vectorSpacing)) << VEC_UNIT_SH);

  // Preempt only on a higher group, or higher subpriority in the same group
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpuIrqRequest <= 1'b0;
      irqVector     <= 6'h00;
      irqVectorAddr <= 32'h0000_0000;
    end else begin
      cpuIrqRequest <= anyLive && (bestKey[4:2] > curGroup ||
                       (bestKey[4:2] == curGroup && bestKey[1:0] > curSub));
      irqVector     <= bestVec;
      irqVectorAddr <= addrNext;
    end
  end

endmodule : adcti_irq_arbiter

// File: hdl/adcti_pkg.sv
// Shared constants and carrier types of the converter trigger and interrupt block
package adcti_pkg;

  // Field positions inside the three control words
  localparam int CR1_ON_BIT       = 15;
  localparam int CR1_CONVERSION_TRIGGER_SOURCE_HI      = 7;
  localparam int CR1_CONVERSION_TRIGGER_SOURCE_LO      = 5;
  localparam int CR1_AUTO_SAMPLE_START_BIT     = 2;
  localparam int CR2_INPUT_SCAN_ENABLE_BIT    = 10;
  localparam int CR2_SMPI_HI      = 5;
  localparam int CR2_SMPI_LO      = 2;
  localparam int CR3_SAMC_HI      = 12;
  localparam int CR3_SAMC_LO      = 8;
  localparam int CR3_ADCS_HI      = 7;
  localparam int CR3_ADCS_LO      = 0;

  // Trigger source codes
  localparam logic [2:0] TRIG_MANUAL  = 3'h0;
  localparam logic [2:0] TRIG_AUTO    = 3'h7;

  // Conversion length in conversion-clock periods
  localparam logic [3:0] CONV_TADS    = 4'hc;

  // Interrupt controller figures
  localparam int          NUM_VEC       = 64;
  localparam int          NUM_IRQ       = 64;
  localparam logic [5:0]  ADC_VECTOR    = 6'h1b;
  localparam int          ADC_IRQ_NUM   = 32;
  localparam logic [2:0]  PRIO_RESET    = 3'h4;
  localparam logic [1:0]  SUBPRIO_RESET = 2'h0;
  localparam logic [2:0]  PRIO_OFF      = 3'h0;
  localparam logic [31:0] VEC_BASE_OFS  = 32'h0000_0200;
  localparam int          VEC_UNIT_SH   = 5;

  // Configuration words as software leaves them
  typedef struct packed {
    logic [15:0] controlRegOne;
    logic [15:0] controlRegTwo;
    logic [15:0] controlRegThree;
    logic [15:0] scanSelectReg;
    logic [15:0] portConfigReg;
    logic [3:0]  positiveInputSel;
  } adcti_cfg_t;

  // One interrupt source as seen by the arbiter
  typedef struct packed {
    logic       flag;
    logic       enable;
    logic [2:0] group;
    logic [1:0] sub;
  } adcti_src_t;

endpackage : adcti_pkg

// File: hdl/adcti_tad_divider.sv
// Conversion clock divider: one-cycle tick per conversion-clock period
`timescale 1ns/10ps
module adcti_tad_divider
  import adcti_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Control
  input  wire logic       run,
  input  wire logic [7:0] divSel,
  // Tick
  output logic            tadTick
);

  logic [8:0] cnt_reg;
  logic [8:0] lastCount;

  // Period is 2*(divSel+1) bus clocks
  assign lastCount = {divSel, 1'b1};

  // Restart on every stop so the first period is always whole
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 9'h000;
      tadTick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 9'h000;
      tadTick <= 1'b0;
    end else if (cnt_reg >= lastCount) begin
      cnt_reg <= 9'h000;
      tadTick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 9'h001;
      tadTick <= 1'b0;
    end
  end

endmodule : adcti_tad_divider

// File: testbench/adcti_control_asserts.sv
// Concurrent checks on the ports of the converter trigger and interrupt block
`timescale 1ns/10ps
module adcti_control_asserts
  import adcti_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               nrst,
  // Stimulus seen by the block
  input wire adcti_cfg_t         cfg,
  input wire logic               sampleSetStrobe,
  input wire logic               sampleClearStrobe,
  input wire logic               irqFlagClear,
  input wire logic               converterIrqEnable,
  input wire logic [31:0]        exceptionBase,
  input wire logic [4:0]         vectorSpacing,
  // Results of the block
  input wire logic               sampleActive,
  input wire logic               convertActive,
  input wire logic [15:0]        analogPinMask,
  input wire logic               sampleControlBit,
  input wire logic               conversionDone,
  input wire logic               converterIrqFlag,
  input wire logic [NUM_IRQ-1:0] irqFlagBits,
  input wire logic [2:0]         converterIrqPriority,
  input wire logic               cpuIrqRequest,
  input wire logic [5:0]         irqVector,
  input wire logic [31:0]        irqVectorAddr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic manualOn, autoOn, adcReq;
  // Decoded trigger mode and a request owned by the converter
  assign manualOn = cfg.controlRegOne[CR1_ON_BIT] && cfg.controlRegOne[CR1_CONVERSION_TRIGGER_SOURCE_HI:CR1_CONVERSION_TRIGGER_SOURCE_LO] == TRIG_MANUAL;
  assign autoOn   = cfg.controlRegOne[CR1_ON_BIT] && cfg.controlRegOne[CR1_CONVERSION_TRIGGER_SOURCE_HI:CR1_CONVERSION_TRIGGER_SOURCE_LO] == TRIG_AUTO;
  assign adcReq   = cpuIrqRequest && irqVector == ADC_VECTOR;
  // Manual end of sampling is two steps: bit drops, then conversion runs
  sequence s_end_sample;
    ##[1:2] !sampleControlBit;
  endsequence
  sequence s_convert;
    ##[1:2] convertActive;
  endsequence
  manual_conv_a: assert property (manualOn && sampleActive && sampleClearStrobe && !sampleSetStrobe
    |-> s_end_sample ##0 s_convert) else $error("manual conversion did not start");
  done_time_a: assert property ($rose(convertActive) |-> ##[20:400] $rose(conversionDone))
    else $error("conversion done outside its window");
  auto_end_a: assert property (autoOn && sampleActive |-> ##[1:300] !sampleControlBit)
    else $error("automatic trigger never ended sampling");
  flag_event_a: assert property ($rose(converterIrqFlag) |-> $rose(conversionDone))
    else $error("interrupt flag rose without a finished conversion");
  flag_hold_a: assert property (converterIrqFlag && !irqFlagClear |=> converterIrqFlag)
    else $error("interrupt flag dropped without a clear");
  req_enable_a: assert property (adcReq |-> $past(converterIrqEnable) && $past(converterIrqFlag))
    else $error("converter request without enable and flag");
  vec_addr_a: assert property (cpuIrqRequest |-> irqVectorAddr == $past(exceptionBase) + VEC_BASE_OFS
    + ((32'(irqVector) * 32'($past(vectorSpacing))) << VEC_UNIT_SH)) else $error("vector address wrong");
  flag_map_a: assert property (irqFlagBits == ({{(NUM_IRQ-1){1'b0}}, converterIrqFlag} << ADC_IRQ_NUM))
    else $error("flag not at its request number");
  mask_follow_a: assert property ($past(nrst) |-> analogPinMask == ~$past(cfg.portConfigReg))
    else $error("analog pin mask wrong");
  prio_reset_a: assert property ($rose(nrst) |-> converterIrqPriority == PRIO_RESET)
    else $error("priority group not at reset level");
endmodule : adcti_control_asserts

bind adcti_control adcti_control_asserts u_chk (.clk_sys, .nrst, .cfg, .sampleSetStrobe, .sampleClearStrobe,
  .irqFlagClear, .converterIrqEnable, .exceptionBase, .vectorSpacing, .sampleActive, .convertActive,
  .analogPinMask, .sampleControlBit, .conversionDone, .converterIrqFlag, .irqFlagBits, .converterIrqPriority,
  .cpuIrqRequest, .irqVector, .irqVectorAddr);

// File: testbench/adcti_sw_model.sv
// Software model on the far side: interrupt service routine that clears the flag
`timescale 1ns/10ps
module adcti_sw_model
  import adcti_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Service control
  input  wire logic       cpuIrqRequest,
  input  wire logic       serviceOn,
  input  wire logic [3:0] svcDelay,
  input  wire logic       clrReq,
  // Flag clear strobe
  output logic            irqFlagClear
);
  logic [4:0] waitCnt;
  logic       armed;
  // Routine runs svcDelay+1 cycles then clears; re-arms only after the request drops,
  // since the request is registered and would otherwise be served twice
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      waitCnt      <= 5'h00;
      armed        <= 1'b1;
      irqFlagClear <= 1'b0;
    end else begin
      irqFlagClear <= clrReq || waitCnt == 5'h01;
      if (waitCnt != 5'h00) begin
        waitCnt <= waitCnt - 5'h01;
      end else if (cpuIrqRequest && serviceOn && armed) begin
        waitCnt <= {1'b0, svcDelay} + 5'h01;
        armed   <= 1'b0;
      end else if (!cpuIrqRequest) begin
        armed <= 1'b1;
      end
    end
  end
endmodule : adcti_sw_model

// File: testbench/tb_top.sv
// Self-checking bench for the converter trigger and interrupt control block
`timescale 1ns/10ps
module tb_top;
  import adcti_pkg::*;
  // Design stimulus
  logic                     clk_sys, nrst, sampleSetStrobe, sampleClearStrobe, irqFlagClear;
  logic                     converterIrqEnable, prioWrite, serviceOn, clrReq;
  logic [2:0]               prioWdata, curGroup;
  logic [1:0]               subprioWdata, curSub;
  logic [3:0]               svcDelay;
  logic [4:0]               vectorSpacing;
  logic [31:0]              exceptionBase;
  adcti_cfg_t               cfg;
  adcti_src_t [NUM_VEC-1:0] otherSources;
  // Design results
  logic                     sampleActive, convertActive, sampleControlBit, conversionDone, converterIrqFlag;
  logic                     cpuIrqRequest;
  logic [3:0]               channelSel;
  logic [15:0]              analogPinMask;
  logic [NUM_IRQ-1:0]       irqFlagBits;
  logic [2:0]               converterIrqPriority;
  logic [1:0]               converterIrqSubpriority;
  logic [5:0]               irqVector;
  logic [31:0]              irqVectorAddr;
  // Reference model state; tables hold addresses per spacing and {group, sub, run group, run sub, request}
  int                       fails, checks_done, smpi, smpCnt, k;
  logic                     expFlag;
  logic [31:0]              addrTab [5] = '{32'h8000_0560, 32'h8000_08c0, 32'h8000_0f80, 32'h8000_1d00,
                                            32'h8000_3800};
  logic [10:0]              prioTab [6] = '{{3'h0, 2'h3, 3'h0, 2'h0, 1'b0}, {3'h3, 2'h3, 3'h4, 2'h0, 1'b0},
                                            {3'h5, 2'h0, 3'h4, 2'h3, 1'b1}, {3'h4, 2'h3, 3'h4, 2'h1, 1'b1},
                                            {3'h7, 2'h0, 3'h6, 2'h3, 1'b1}, {3'h4, 2'h2, 3'h4, 2'h2, 1'b0}};

  adcti_control dut (.clk_sys, .nrst, .cfg, .sampleSetStrobe, .sampleClearStrobe, .irqFlagClear, .converterIrqEnable,
    .prioWrite, .prioWdata, .subprioWdata, .otherSources, .curGroup, .curSub, .exceptionBase, .vectorSpacing,
    .convertDoneAnalog(1'b0), .sampleActive, .convertActive, .channelSel, .analogPinMask, .sampleControlBit,
    .conversionDone, .converterIrqFlag, .irqFlagBits, .converterIrqPriority, .converterIrqSubpriority,
    .cpuIrqRequest, .irqVector, .irqVectorAddr);
  adcti_sw_model sw (.clk_sys, .nrst, .cpuIrqRequest, .serviceOn, .svcDelay, .clrReq, .irqFlagClear);

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      fails++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  // Bounded wait for done; the model counts samples and predicts the sticky flag
  task automatic wait_done();
    int n;
    for (n = 0; n < 400 && conversionDone !== 1'b1; n++) tick(1);
    if (n == 400) begin
      fails++;
      finish_test();
    end
    smpCnt++;
    if (smpCnt > smpi) begin
      smpCnt = 0;
      expFlag = 1'b1;
    end
    check(32'(converterIrqFlag), 32'(expFlag));
  endtask : wait_done
  task automatic conv(input int hold);
    pulse(sampleSetStrobe);
    tick(hold);
    pulse(sampleClearStrobe);
    tick(3);
    wait_done();
  endtask : conv
  task automatic clr_flag();
    pulse(clrReq);
    tick(2);
    expFlag = 1'b0;
    check(32'(converterIrqFlag), 32'h0);
  endtask : clr_flag

  initial begin
    k = $urandom(21833);
    {nrst, sampleSetStrobe, sampleClearStrobe, converterIrqEnable, prioWrite, serviceOn, clrReq} = '0;
    {prioWdata, subprioWdata, curGroup, curSub, svcDelay} = '0;
    cfg = '0;
    otherSources = '0;
    exceptionBase = 32'h8000_0000;
    vectorSpacing = 5'h01;
    fails = 0;
    checks_done = 0;
    smpi = 0;
    smpCnt = 0;
    expFlag = 1'b0;
    cfg.portConfigReg = 16'hfffb;
    tick(3);
    nrst = 1'b1;
    tick(1);
    // Reset levels and pin mode map
    check(32'(converterIrqPriority), 32'(PRIO_RESET));
    check(32'(converterIrqSubpriority), 32'(SUBPRIO_RESET));
    check(32'(analogPinMask), 32'h0004);
    cfg.portConfigReg = 16'h0000;
    tick(2);
    check(32'(analogPinMask), 32'hffff);
    // Strobe while off starts nothing; manual mode ignores the long sample time, and the scan list is unused with scanning off
    cfg.controlRegThree = 16'h1f00;
    cfg.scanSelectReg = 16'h00f0;
    cfg.positiveInputSel = 4'($urandom_range(0, 15));
    pulse(sampleSetStrobe);
    tick(8);
    check(32'(sampleActive), 32'h0);
    cfg.controlRegOne = 16'h8000;
    pulse(sampleSetStrobe);
    tick(80);
    check(32'(sampleActive), 32'h1);
    check(32'(channelSel), 32'(cfg.positiveInputSel));
    pulse(sampleClearStrobe);
    tick(3);
    wait_done();
    // Random samples-per-interrupt counts, polled with the enable low
    repeat (3) begin
      smpi = $urandom_range(0, 3);
      cfg.controlRegTwo = 16'(smpi << CR2_SMPI_LO);
      clr_flag();
      repeat (2 * smpi + 2) begin
        conv(4);
        check(32'(cpuIrqRequest), 32'h0);
      end
    end
    // Enabled top-group request: vector, flag position and placement per spacing
    cfg.controlRegTwo = 16'h0000;
    smpi = 0;
    clr_flag();
    {prioWdata, subprioWdata} = {3'h7, 2'h1};
    pulse(prioWrite);
    converterIrqEnable = 1'b1;
    conv(4);
    tick(2);
    check(32'(cpuIrqRequest), 32'h1);
    check(32'(irqVector), 32'(ADC_VECTOR));
    check(irqFlagBits[63:32], 32'h1);
    check(irqFlagBits[31:0], 32'h0);
    for (k = 0; k < 5; k++) begin
      vectorSpacing = 5'(1 << k);
      tick(2);
      check(irqVectorAddr, addrTab[k]);
    end
    vectorSpacing = 5'h01;
    // Group zero silences; higher group or subpriority preempts the running level
    for (k = 0; k < 6; k++) begin
      {prioWdata, subprioWdata, curGroup, curSub} = prioTab[k][10:1];
      pulse(prioWrite);
      tick(2);
      check(32'(converterIrqPriority), 32'(prioTab[k][10:8]));
      check(32'(cpuIrqRequest), 32'(prioTab[k][0]));
    end
    // Equal levels: lower vector wins, converter taken once the other clears
    {curGroup, curSub} = '0;
    otherSources[40] = {1'b1, 1'b1, 3'h4, 2'h2};
    otherSources[20] = {1'b1, 1'b1, 3'h4, 2'h2};
    tick(3);
    check(32'(irqVector), 32'h14);
    otherSources[20] = '0;
    tick(3);
    check(32'(irqVector), 32'(ADC_VECTOR));
    otherSources[40] = '0;
    // Service routine clears the flag; a later event is served again
    svcDelay = 4'($urandom_range(0, 7));
    serviceOn = 1'b1;
    repeat (2) begin
      tick(20);
      check(32'(converterIrqFlag), 32'h0);
      check(32'(cpuIrqRequest), 32'h0);
      expFlag = 1'b0;
      conv(4);
    end
    // Internal counter ends sampling after two conversion-clock periods
    serviceOn = 1'b0;
    cfg.controlRegThree = 16'h0203;
    cfg.controlRegOne = 16'h80e0;
    pulse(sampleSetStrobe);
    for (k = 0; k < 100 && convertActive !== 1'b1; k++) tick(1);
    check(32'(k >= 8 && k <= 20), 32'h1);
    check(32'(sampleControlBit), 32'h0);
    wait_done();
    finish_test();
  end
endmodule : tb_top
